/* File: hdl/rscd_pkg.sv */
// Package for the reset strap configuration decoder.
// Assumes one 100 MHz core clock and an APB register port.
package rscd_pkg;
   localparam int unsigned STRAP_W        = 20;
   // Register byte offsets
   localparam logic [11:0] OFF_STRAP_RAW  = 12'h000;
   localparam logic [11:0] OFF_DECODED    = 12'h004;
   localparam logic [11:0] OFF_CONTROL    = 12'h008;
   // Strap field positions
   localparam int unsigned POS_STALL      = 0;
   localparam int unsigned POS_LANE_REV   = 2;
   localparam int unsigned POS_EDP_OFF    = 4;
   localparam int unsigned POS_BIF_LO     = 5;
   localparam int unsigned POS_TRAIN_NOW  = 7;
   // Control register bits
   localparam int unsigned POS_FW_TRAIN   = 0;
   localparam int unsigned POS_HAS_GFX    = 1;
   // Reset values
   localparam logic [19:0] STRAP_RST      = 20'hfffff;
   localparam logic [1:0]  CTRL_RST       = 2'h2;
   // Bifurcation encodings
   localparam logic [1:0]  BIF_X8_2X4     = 2'h0;
   localparam logic [1:0]  BIF_RSVD       = 2'h1;
   localparam logic [1:0]  BIF_2X8        = 2'h2;
   localparam logic [1:0]  BIF_X16        = 2'h3;
   // Settle time after platform reset release before straps are captured
   localparam int unsigned SETTLE_NS      = 100;
   localparam int unsigned CLK_NS         = 10;
   localparam int unsigned SETTLE_CYC     = (SETTLE_NS + CLK_NS - 1) / CLK_NS;

   typedef enum logic [1:0] {RSCD_IN_RESET, RSCD_SETTLE, RSCD_STALLED, RSCD_RUN} rscd_state_t;

   // Decoded configuration delivered to the consumers
   typedef struct packed {
      logic       seq_stalled;
      logic       lane_reverse;
      logic       edp_enable;
      logic [1:0] bifurcation;
      logic       train_start;
   } rscd_cfg_t;
endpackage : rscd_pkg

/* File: hdl/rscd_sync3.sv */
// Three-flop synchroniser with agreement filter for strap pins.
// Assumes inputs are asynchronous to core_clk.
`timescale 1ns/1ns
module rscd_sync3 #(
   parameter int unsigned W   = 1,
   parameter logic [W-1:0] RV = '1
) (
   input  wire logic         core_clk,
   input  wire logic         arst_n,
   input  wire logic [W-1:0] din,
   output logic      [W-1:0] dout
);
   logic [W-1:0] s1_q;
   logic [W-1:0] s2_q;
   logic [W-1:0] s3_q;

   // First stage is read only by the second; change accepted when stages 2 and 3 agree
   always_ff @(posedge core_clk or negedge arst_n) begin
      if (!arst_n) begin
         s1_q <= RV;
         s2_q <= RV;
         s3_q <= RV;
         dout <= RV;
      end else begin
         s1_q <= din;
         s2_q <= s1_q;
         s3_q <= s2_q;
         // Each bit holds while stages 2 and 3 disagree, so a pin change must last two samples to pass
         dout <= (dout & (s2_q ^ s3_q)) | (s3_q & ~(s2_q ^ s3_q));
      end
   end
endmodule : rscd_sync3

/* File: hdl/rscd_top.sv */
// Strap decoder: samples configuration straps around platform reset and drives
// the reset sequencer, graphics port and display enables. APB register port.
// Assumes board pull-ups hold unterminated straps high; platform reset is a pin.
//
// Decided for this implementation: the register addresses and the APB interface to the registers.
`timescale 1ns/1ns
// Behaviour
// - Unterminated strap reads as one; every default setting equals one.
// - Strap bit 0 low stalls reset sequence after PLL lock until released.
// - Strap bit 2 low reverses sixteen-lane graphics port lane numbers.
// - Strap bit 4 one disables embedded display, zero enables it.
// - Bits 6:5 pick bifurcation: 00 x8+2x4, 10 2x8, 11 x16, 01 reserved.
// - Bit 7 one trains link at reset release; zero waits for firmware.
// - Bits 2, 6:5, 7 apply only in variants with graphics port.
module rscd_top (
   input  wire logic                  core_clk,
   input  wire logic                  arst_n,
   input  wire logic [19:0]           strap_pin,
   input  wire logic                  plat_rst_n,
   input  wire logic                  pll_locked,
   input  wire logic                  psel,
   input  wire logic                  penable,
   input  wire logic                  pwrite,
   input  wire logic [11:0]           paddr,
   input  wire logic [31:0]           pwdata,
   output logic      [31:0]           prdata,
   output logic                       pready,
   output logic                       pslverr,
   output rscd_pkg::rscd_cfg_t        cfg_q,
   output logic                       seq_go_q
);
   logic [19:0]           strap_s;
   logic                  prst_s;
   logic [19:0]           strap_q;
   logic [1:0]            ctrl_q;
   logic                  fw_train_q;
   logic [7:0]            settle_q;
   rscd_pkg::rscd_state_t st_q;
   logic                  acc;

   // Straps reset to all ones so an open pin decodes as its default
   rscd_sync3 #(.W(20), .RV(rscd_pkg::STRAP_RST)) u_strap (
      .core_clk (core_clk),
      .arst_n   (arst_n),
      .din      (strap_pin),
      .dout     (strap_s)
   );

   // Platform reset pin from the hub is asynchronous too
   rscd_sync3 #(.W(1), .RV(1'b0)) u_prst (
      .core_clk (core_clk),
      .arst_n   (arst_n),
      .din      (plat_rst_n),
      .dout     (prst_s)
   );

   // Bifurcation decode; reserved code falls back to the x16 default
   function automatic logic [1:0] bif_dec(input logic [1:0] f, input logic gfx);
      if (!gfx) bif_dec = rscd_pkg::BIF_X16;
      else if (f == rscd_pkg::BIF_RSVD) bif_dec = rscd_pkg::BIF_X16;
      else bif_dec = f;
   endfunction : bif_dec

   // Sequencer: capture after settle, then stall or run
   always_ff @(posedge core_clk or negedge arst_n) begin
      if (!arst_n) begin
         st_q     <= rscd_pkg::RSCD_IN_RESET;
         settle_q <= 8'h00;
      end else begin
         case (st_q)
            rscd_pkg::RSCD_IN_RESET: begin
               settle_q <= 8'h00;
               if (prst_s) st_q <= rscd_pkg::RSCD_SETTLE;
            end
            rscd_pkg::RSCD_SETTLE: begin
               settle_q <= settle_q + 8'h01;
               if (!prst_s) st_q <= rscd_pkg::RSCD_IN_RESET;
               else if (settle_q == 8'(rscd_pkg::SETTLE_CYC - 1) && pll_locked)
                  st_q <= strap_s[rscd_pkg::POS_STALL] ? rscd_pkg::RSCD_RUN
                                                       : rscd_pkg::RSCD_STALLED;
               else if (settle_q == 8'(rscd_pkg::SETTLE_CYC - 1)) settle_q <= settle_q;
            end
            rscd_pkg::RSCD_STALLED: begin
               if (!prst_s) st_q <= rscd_pkg::RSCD_IN_RESET;
               else if (strap_s[rscd_pkg::POS_STALL]) st_q <= rscd_pkg::RSCD_RUN;
            end
            rscd_pkg::RSCD_RUN: begin
               if (!prst_s) st_q <= rscd_pkg::RSCD_IN_RESET;
            end
            default: st_q <= rscd_pkg::RSCD_IN_RESET;
         endcase
      end
   end

   // Static straps latched once at the end of settle; held until next reset
   always_ff @(posedge core_clk or negedge arst_n) begin
      if (!arst_n) begin
         strap_q <= rscd_pkg::STRAP_RST;
      end else if (st_q == rscd_pkg::RSCD_SETTLE
                   && settle_q == 8'(rscd_pkg::SETTLE_CYC - 1) && pll_locked) begin
         strap_q <= strap_s;
      end
   end

   // Decoded outputs
   always_ff @(posedge core_clk or negedge arst_n) begin
      if (!arst_n) begin
         cfg_q    <= '0;
         seq_go_q <= 1'b0;
      end else begin
         cfg_q.seq_stalled  <= (st_q == rscd_pkg::RSCD_STALLED);
         seq_go_q           <= (st_q == rscd_pkg::RSCD_RUN);
         cfg_q.lane_reverse <= ctrl_q[rscd_pkg::POS_HAS_GFX]
                               & ~strap_q[rscd_pkg::POS_LANE_REV];
         cfg_q.edp_enable   <= ~strap_q[rscd_pkg::POS_EDP_OFF];
         cfg_q.bifurcation  <= bif_dec(strap_q[rscd_pkg::POS_BIF_LO +: 2],
                                       ctrl_q[rscd_pkg::POS_HAS_GFX]);
         // Link only trains once the sequence runs, never during stall
         cfg_q.train_start  <= ctrl_q[rscd_pkg::POS_HAS_GFX]
                               && (st_q == rscd_pkg::RSCD_RUN)
                               && (strap_q[rscd_pkg::POS_TRAIN_NOW] || fw_train_q);
      end
   end

   // APB: one wait state, since pready comes from a flop; acc marks the first access cycle
   assign acc = psel & penable & ~pready;

   // Control register: firmware training start and graphics variant flag
   always_ff @(posedge core_clk or negedge arst_n) begin
      if (!arst_n) begin
         ctrl_q     <= rscd_pkg::CTRL_RST;
         fw_train_q <= 1'b0;
      end else if (st_q == rscd_pkg::RSCD_IN_RESET) begin
         fw_train_q <= 1'b0; // Request does not survive a platform reset
      end else if (psel && penable && pready && pwrite && paddr == rscd_pkg::OFF_CONTROL) begin
         ctrl_q     <= pwdata[1:0];
         fw_train_q <= fw_train_q | pwdata[rscd_pkg::POS_FW_TRAIN];
      end
   end

   // Read mux and handshake
   always_ff @(posedge core_clk or negedge arst_n) begin
      if (!arst_n) begin
         prdata  <= 32'h0000_0000;
         pready  <= 1'b0;
         pslverr <= 1'b0;
      end else begin
         pready  <= acc;
         pslverr <= 1'b0;
         if (acc) begin
            case (paddr)
               rscd_pkg::OFF_STRAP_RAW: prdata <= {12'h000, strap_q};
               rscd_pkg::OFF_DECODED:   prdata <= {26'h0000000, cfg_q};
               rscd_pkg::OFF_CONTROL:   prdata <= {30'h00000000, ctrl_q};
               default: begin
                  prdata  <= 32'h0000_0000;
                  pslverr <= 1'b1;
               end
            endcase
         end
      end
   end

   // Assertions
   property p_stall_hold;
      @(posedge core_clk) disable iff (!arst_n)
      (st_q == rscd_pkg::RSCD_STALLED && !strap_s[0] && prst_s) |=> st_q == rscd_pkg::RSCD_STALLED;
   endproperty
   a_stall_hold: assert property (p_stall_hold) else $error("stall left early");
   property p_release;
      @(posedge core_clk) disable iff (!arst_n)
      (st_q == rscd_pkg::RSCD_STALLED && strap_s[0] && prst_s) |=> ##1 seq_go_q;
   endproperty
   a_release: assert property (p_release) else $error("no run after release");
   property p_edp;
      @(posedge core_clk) disable iff (!arst_n)
      $stable(strap_q) |=> cfg_q.edp_enable == !$past(strap_q[4]);
   endproperty
   a_edp: assert property (p_edp) else $error("display sense wrong");
   property p_lane;
      @(posedge core_clk) disable iff (!arst_n)
      1 |=> cfg_q.lane_reverse == ($past(ctrl_q[1]) && !$past(strap_q[2]));
   endproperty
   a_lane: assert property (p_lane) else $error("lane reverse wrong");
   property p_bif;
      @(posedge core_clk) disable iff (!arst_n)
      1 |=> cfg_q.bifurcation != rscd_pkg::BIF_RSVD;
   endproperty
   a_bif: assert property (p_bif) else $error("reserved bifurcation out");
   property p_nogfx;
      @(posedge core_clk) disable iff (!arst_n)
      !ctrl_q[1] |=> !cfg_q.train_start && !cfg_q.lane_reverse;
   endproperty
   a_nogfx: assert property (p_nogfx) else $error("graphics strap used");
   property p_train;
      @(posedge core_clk) disable iff (!arst_n)
      // Keyed on the state, not seq_go_q, which lags a platform reset by one cycle
      (st_q == rscd_pkg::RSCD_RUN && ctrl_q[1] && strap_q[7]) |=> cfg_q.train_start;
   endproperty
   a_train: assert property (p_train) else $error("no immediate training");
   property p_hold;
      @(posedge core_clk) disable iff (!arst_n)
      (st_q == rscd_pkg::RSCD_RUN) |=> $stable(strap_q);
   endproperty
   a_hold: assert property (p_hold) else $error("straps changed in run");
   property p_dflt;
      @(posedge core_clk) disable iff (!arst_n)
      (strap_s == rscd_pkg::STRAP_RST && st_q == rscd_pkg::RSCD_SETTLE && pll_locked && prst_s)
         |-> ##[1:12] seq_go_q;
   endproperty
   a_dflt: assert property (p_dflt) else $error("defaults do not run");
   // Before PLL lock the sequence must neither run nor stall
   property p_pll_wait;
      @(posedge core_clk) disable iff (!arst_n)
      (st_q == rscd_pkg::RSCD_SETTLE && !pll_locked)
         |=> (st_q == rscd_pkg::RSCD_SETTLE || st_q == rscd_pkg::RSCD_IN_RESET);
   endproperty
   a_pll_wait: assert property (p_pll_wait) else $error("left settle before lock");
   // A platform reset always drops a pending firmware training request
   property p_fw_clear;
      @(posedge core_clk) disable iff (!arst_n)
      (st_q == rscd_pkg::RSCD_IN_RESET) |=> !fw_train_q;
   endproperty
   a_fw_clear: assert property (p_fw_clear) else $error("training request kept");
   c_stall: cover property (@(posedge core_clk) st_q == rscd_pkg::RSCD_STALLED ##1
                            st_q == rscd_pkg::RSCD_RUN);
   c_train: cover property (@(posedge core_clk) cfg_q.train_start);
   c_rd:    cover property (@(posedge core_clk) pready && !pslverr);
   c_pll:   cover property (@(posedge core_clk) st_q == rscd_pkg::RSCD_SETTLE && !pll_locked);
endmodule : rscd_top

/* File: tb/rscd_board.sv */
// Board model: strap resistors and the platform hub reset driver.
// Assumes the bench chooses which straps are tied and when the hub resets.
`timescale 1ns/1ns
module rscd_board (
   input  wire logic [19:0] tie_en,
   input  wire logic [19:0] tie_val,
   input  wire logic        hub_rst_req,
   output logic      [19:0] strap_pin,
   output logic             plat_rst_n
);
   // Open straps are pulled up, so they never float to a random level
   always_comb strap_pin = (tie_en & tie_val) | ~tie_en;
   // Hub holds the platform reset low while a reset is requested
   always_comb plat_rst_n = ~hub_rst_req;
endmodule : rscd_board

/* File: tb/test_reset_strap_config_decoder.sv */
// Self-checking bench for the strap decoder, with APB master tasks.
// Assumes rscd_top and the board model; pll_locked rises after core reset.
`timescale 1ns/1ns
module test_reset_strap_config_decoder;
   logic                core_clk, arst_n, pll_locked, psel, penable, pwrite;
   logic                pready, pslverr, seq_go_q, plat_rst_n, hub_rst_req, er;
   logic [11:0]         paddr;
   logic [31:0]         pwdata, prdata, rd;
   logic [19:0]         strap_pin, tie_en, tie_val;
   rscd_pkg::rscd_cfg_t cfg_q;
   int                  failures, samples_checked, cycles;

   rscd_top rscd_top_i (.core_clk(core_clk), .arst_n(arst_n), .strap_pin(strap_pin),
      .plat_rst_n(plat_rst_n), .pll_locked(pll_locked), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .cfg_q(cfg_q), .seq_go_q(seq_go_q));
   rscd_board rscd_board_i (.tie_en(tie_en), .tie_val(tie_val),
      .hub_rst_req(hub_rst_req), .strap_pin(strap_pin), .plat_rst_n(plat_rst_n));

   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      samples_checked++;
      if (seen !== exp) begin
         failures++;
         $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask : check

   task automatic tally_and_finish;
      if (failures == 0 && samples_checked > 0) $display("[ PASS ]");
      else $display("[ FAIL ]");
      $finish;
   endtask : tally_and_finish

   // One APB transfer; request held until pready is seen high at a rising edge
   task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
      int n;
      @(posedge core_clk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge core_clk);
      penable <= 1'b1;
      n = 0;
      // Sampled at the rising edge, so read data and error are taken where pready is seen
      do begin @(posedge core_clk); n++; end while (pready !== 1'b1 && n < 20);
      rd = prdata;
      er = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      check(n < 20, 32'h1);
   endtask : apb

   // Decoded settings expected from the low strap byte and control bits
   function automatic logic [31:0] exp_cfg(input logic [7:0] s, input logic g, input logic f);
      rscd_pkg::rscd_cfg_t c;
      c.seq_stalled  = ~s[0];
      c.lane_reverse = g & ~s[2];
      c.edp_enable   = ~s[4];
      c.bifurcation  = (!g || s[6:5] == rscd_pkg::BIF_RSVD) ? rscd_pkg::BIF_X16 : s[6:5];
      c.train_start  = g & s[0] & (s[7] | f);
      return {26'h0, c};
   endfunction : exp_cfg

   // Platform reset pulse with new strap ties, then wait for run or stall
   task automatic plat_boot(input logic [19:0] en, input logic [19:0] val);
      int n;
      @(posedge core_clk);
      hub_rst_req <= 1'b1;
      tie_en <= en;
      tie_val <= val;
      repeat (8) @(posedge core_clk);
      hub_rst_req <= 1'b0;
      n = 0;
      do begin @(negedge core_clk); n++; end
         while (seq_go_q !== 1'b1 && cfg_q.seq_stalled !== 1'b1 && n < 60);
      repeat (2) @(negedge core_clk);
      check(n < 60, 32'h1);
   endtask : plat_boot

   task automatic t_default;
      plat_boot(20'h0, 20'h0);
      check({26'h0, cfg_q}, exp_cfg(8'hff, 1'b1, 1'b0));
      apb(1'b0, rscd_pkg::OFF_STRAP_RAW, 32'h0);
      check(rd, 32'h000fffff);
      tie_en <= 20'hfffff; // Straps change after capture
      repeat (20) @(posedge core_clk);
      check({31'h0, seq_go_q}, 32'h1);
      check({26'h0, cfg_q}, exp_cfg(8'hff, 1'b1, 1'b0));
      apb(1'b1, rscd_pkg::OFF_STRAP_RAW, 32'h0);
      apb(1'b0, rscd_pkg::OFF_STRAP_RAW, 32'h0);
      check(rd, 32'h000fffff);
      apb(1'b0, 12'h00c, 32'h0);
      check({er, rd[30:0]}, 32'h80000000);
   endtask : t_default

   task automatic t_codes;
      logic [7:0] s;
      for (int i = 0; i < 4; i++) begin
         s = {1'b0, 2'(i), 5'b01011};
         plat_boot(20'h000ff, {12'h0, s});
         check({26'h0, cfg_q}, exp_cfg(s, 1'b1, 1'b0));
         apb(1'b0, rscd_pkg::OFF_DECODED, 32'h0);
         check(rd, exp_cfg(s, 1'b1, 1'b0));
         apb(1'b0, rscd_pkg::OFF_CONTROL, 32'h0);
         // Bit 0 keeps what the previous pass wrote; only the internal request is cleared
         check(rd, (i == 0) ? 32'h2 : 32'h3);
         apb(1'b1, rscd_pkg::OFF_CONTROL, 32'h3);
         repeat (4) @(negedge core_clk);
         check({26'h0, cfg_q}, exp_cfg(s, 1'b1, 1'b1));
      end
   endtask : t_codes

   task automatic t_stall;
      int n;
      plat_boot(20'h00001, 20'h0);
      repeat (20) @(negedge core_clk);
      check({30'h0, cfg_q.seq_stalled, seq_go_q}, 32'h2);
      @(posedge core_clk);
      tie_en <= 20'h0; // Stall strap released
      n = 0;
      do begin @(negedge core_clk); n++; end while (seq_go_q !== 1'b1 && n < 30);
      repeat (2) @(negedge core_clk);
      check({30'h0, cfg_q.seq_stalled, seq_go_q}, 32'h1);
   endtask : t_stall

   // Boot with the PLL unlocked: nothing may run or stall until lock arrives
   task automatic t_pll;
      @(posedge core_clk);
      pll_locked <= 1'b0;
      hub_rst_req <= 1'b1;
      tie_en <= 20'h0;
      repeat (8) @(posedge core_clk);
      hub_rst_req <= 1'b0;
      repeat (40) @(negedge core_clk);
      check({30'h0, cfg_q.seq_stalled, seq_go_q}, 32'h0);
      @(posedge core_clk);
      pll_locked <= 1'b1;
      repeat (4) @(negedge core_clk);
      check({30'h0, cfg_q.seq_stalled, seq_go_q}, 32'h1);
   endtask : t_pll

   task automatic t_nogfx;
      apb(1'b1, rscd_pkg::OFF_CONTROL, 32'h0);
      plat_boot(20'h000ff, 20'h000cb);
      apb(1'b1, rscd_pkg::OFF_CONTROL, 32'h1);
      repeat (4) @(negedge core_clk);
      check({26'h0, cfg_q}, exp_cfg(8'hcb, 1'b0, 1'b1));
   endtask : t_nogfx

   // Free-running core clock
   initial begin
      core_clk = 1'b0;
      forever #5 core_clk = ~core_clk;
   end

   // Hang guard: well above the few hundred cycles the scenarios need
   always @(posedge core_clk) begin
      cycles++;
      if (cycles == 20000) begin
         failures++;
         tally_and_finish();
      end
   end

   // Main sequence
   initial begin
      {arst_n, pll_locked, psel, penable, pwrite, paddr, pwdata} = '0;
      {tie_en, tie_val} = '0;
      hub_rst_req = 1'b1;
      repeat (6) @(posedge core_clk);
      arst_n <= 1'b1;
      pll_locked <= 1'b1;
      t_default();
      t_codes();
      t_stall();
      t_pll();
      t_nogfx();
      tally_and_finish();
   end
endmodule : test_reset_strap_config_decoder
